//--- fipg_regs.svh
// Register map, field positions, reset values and timing counts of the fault gate unit.
// Assumes a 32-bit APB slave with byte addresses and one register per aligned word.
`ifndef FIPG_REGS_SVH
`define FIPG_REGS_SVH

// ==========================================
// Register offsets
`define FIPG_OFS_CTRL 12'h000
`define FIPG_OFS_STATUS 12'h004
`define FIPG_OFS_IRQ_STAT 12'h008
`define FIPG_OFS_IRQ_MASK 12'h00C
`define FIPG_OFS_LANE_MODE 12'h010
`define FIPG_OFS_DEADTIME 12'h014
`define FIPG_OFS_CTRL_PERIOD 12'h018
`define FIPG_OFS_HEARTBEAT 12'h01C
`define FIPG_OFS_LIM_LO 12'h040
`define FIPG_OFS_LIM_HI 12'h060

// ==========================================
// Field positions
`define FIPG_CTRL_RUN 0
`define FIPG_CTRL_WDG_EN 1
`define FIPG_CTRL_CLEAR 2
`define FIPG_EVT_ILK 0
`define FIPG_EVT_LIM 1
`define FIPG_EVT_WDG 2

// ==========================================
// Reset values
`define FIPG_RST_LANE_MODE 8'h00
`define FIPG_RST_DEADTIME 16'h0000
`define FIPG_RST_PERIOD 24'h00_0000
`define FIPG_RST_LIM_LO 16'h8000
`define FIPG_RST_LIM_HI 16'h7FFF

// ==========================================
// Timing: clock rate and interlock response window
`define FIPG_MCLK_MHZ 250
`define FIPG_ILK_DLY_MIN_MS 0.58
`define FIPG_ILK_DLY_MAX_MS 13.19
`define FIPG_ILK_FILT_CYC int'($ceil(`FIPG_ILK_DLY_MIN_MS * 1000.0 * `FIPG_MCLK_MHZ))

`endif

//--- fipg_pkg.sv
// Types shared by the fault gate unit files.
// Assumes nothing beyond a SystemVerilog compiler.
package fipg_pkg;

  // ==========================================
  // Per-channel lane pairing mode
  typedef enum logic [1:0] {FIPG_MODE_HL, FIPG_MODE_AUTH, FIPG_MODE_INDEP} fipg_mode_e;

  // ==========================================
  // Overall execution state
  typedef enum logic [1:0] {FIPG_ST_IDLE, FIPG_ST_RUN, FIPG_ST_FAULT} fipg_state_e;

endpackage : fipg_pkg

//--- fipg_deadtime.sv
// Dead time generator for one lane pair: high and low side from one modulator signal.
// Assumes sig is synchronous to mclk and dt is a count of mclk cycles.
`timescale 1ns/10ps
module fipg_deadtime (
  input wire logic mclk, // System clock
  input wire logic rst, // Synchronous reset, active high
  input wire logic sig, // Modulator signal
  input wire logic [15:0] dt, // Dead time in cycles
  output logic hi, // High-side gate
  output logic lo // Low-side gate
);

  logic sig_ff;
  logic [15:0] cnt_ff;
  logic hi_ff;
  logic lo_ff;
  wire logic edge_seen = sig != sig_ff;
  wire logic cnt_top = cnt_ff == 16'hFFFF;
  wire logic dt_done = cnt_ff >= dt;

  // Count cycles since the last edge, saturating
  always_ff @(posedge mclk) begin
    if (rst) begin
      sig_ff <= 1'b0;
      cnt_ff <= 16'h0000;
    end else begin
      sig_ff <= sig;
      if (edge_seen) begin
        cnt_ff <= 16'h0000;
      end else if (!cnt_top) begin
        cnt_ff <= cnt_ff + 16'h0001;
      end
    end
  end

  // [R13] Rising edges only delayed
  always_ff @(posedge mclk) begin
    if (rst) begin
      hi_ff <= 1'b0;
      lo_ff <= 1'b0;
    end else begin
      hi_ff <= sig_ff && dt_done;
      lo_ff <= !sig_ff && dt_done;
    end
  end

  assign hi = hi_ff;
  assign lo = lo_ff;

  // Both sides never on together
  chk_no_overlap: assert property (@(posedge mclk) disable iff (rst) !(hi_ff && lo_ff)) // [R10]
    else $error("high and low side gates overlap");

  // A side only turns on after the full dead time
  chk_rise_delay: assert property (@(posedge mclk) disable iff (rst) // [R13]
    $rose(hi_ff) || $rose(lo_ff) |-> $past(cnt_ff) >= $past(dt))
    else $error("gate turned on before dead time elapsed");

endmodule : fipg_deadtime

//--- fipg_top.sv
// Fault gate unit: interlock inputs, analog safety limits, heartbeat timer, PWM lane gating.
// Assumes APB master on mclk, inputs synchronous to mclk, one sample per adc_valid pulse.
//
// Summary of operation
// [R1] Interlock output stays high without fault, goes low while a fault is present.
// [R2] External appliance drives interlock input high, pulls it low to signal fault.
// [R3] Any fault blocks all eight PWM lanes.
// [R4] External interlock fault blocks lanes between 0.58 ms and 13.19 ms later.
// [R5] Unconnected second interlock input reads high and never signals a fault.
// [R6] Both interlocks and eight analog limits feed the state and gate the lanes.
// [R7] Heartbeat timeout is 2.5 control periods; a missing heartbeat raises a fault.
// [R8] Sample beyond low or high limit blocks lanes at once and enters fault.
// [R9] By default two consecutive lanes form one channel.
// [R10] High/low mode gives complementary gates with configurable dead time between ones.
// [R11] Authorization mode: one lane switches, the other enables the converter.
// [R12] Independent mode: each lane follows its own modulator, no dead time.
// [R13] Dead time delays only rising edges, half dead time effective delay.
// [R14] Odd lanes are low side, even lanes are high side.
// [R15] Fault and blocking stay latched until software clears them.
//
// The APB slave port and the address map were left to the implementer.
`timescale 1ns/10ps
`include "fipg_regs.svh"
module fipg_top #(
  parameter int ILK_FILT_CYC = `FIPG_ILK_FILT_CYC // Interlock low time before fault
) (
  input wire logic mclk, // System clock, 250 MHz
  input wire logic rst, // Synchronous reset, active high
  input wire logic psel, // APB select
  input wire logic penable, // APB enable
  input wire logic pwrite, // APB write
  input wire logic [11:0] paddr, // APB byte address
  input wire logic [31:0] pwdata, // APB write data
  output logic [31:0] prdata, // APB read data
  output logic pready, // APB ready
  output logic pslverr, // APB error on unmapped address
  input wire logic [1:0] interlock_ok_in_n, // Interlock inputs, low is fault
  output logic interlock_ok_out_n, // Interlock output, low is fault
  input wire logic adc_valid, // Analog sample strobe
  input wire logic [2:0] adc_chan, // Analog channel of the sample
  input wire logic [15:0] adc_data, // Signed analog sample
  input wire logic [7:0] mod_sig, // Modulator signal per lane
  output logic [7:0] gate_lane, // Gated optical lanes
  output logic irq // Interrupt, high while unmasked event pending
);

  // ==========================================
  // Functions
  function automatic logic fipg_outside(input logic [15:0] s, input logic [15:0] lo, input logic [15:0] hi);
    fipg_outside = ($signed(s) < $signed(lo)) || ($signed(s) > $signed(hi));
  endfunction : fipg_outside

  function automatic logic [25:0] fipg_wdg_limit(input logic [23:0] per);
    fipg_wdg_limit = {1'b0, per, 1'b0} + {3'b000, per[23:1]};
  endfunction : fipg_wdg_limit

  localparam logic [23:0] ILK_LIM = 24'(ILK_FILT_CYC);

  // ==========================================
  // Registers
  fipg_pkg::fipg_state_e state_ff, nxt_state;
  logic run_ff;
  logic wdg_en_ff;
  logic [2:0] irq_stat_ff;
  logic [2:0] irq_mask_ff;
  logic [2:0] cause_ff;
  logic [7:0] mode_ff;
  logic [15:0] dt_ff;
  logic [23:0] period_ff;
  logic [15:0] lim_lo_mem [0:7];
  logic [15:0] lim_hi_mem [0:7];
  logic [23:0] ilk_cnt_ff [0:1];
  logic [25:0] wdg_cnt_ff;
  logic [31:0] prdata_ff;
  logic pready_ff;
  logic pslverr_ff;
  logic ok_out_n_ff;
  logic [7:0] lane_ff;
  logic irq_ff;

  // ==========================================
  // APB decode: one wait state, access completes when pready_ff is high
  wire logic acc_go = psel && penable && pready_ff;
  wire logic wr = acc_go && pwrite;
  wire logic lim_lo_hit = paddr[11:5] == 7'(`FIPG_OFS_LIM_LO >> 5) && paddr[1:0] == 2'b00;
  wire logic lim_hi_hit = paddr[11:5] == 7'(`FIPG_OFS_LIM_HI >> 5) && paddr[1:0] == 2'b00;
  wire logic [2:0] lim_idx = paddr[4:2];
  wire logic wr_ctrl = wr && paddr == `FIPG_OFS_CTRL;
  wire logic wr_hb = wr && paddr == `FIPG_OFS_HEARTBEAT;
  wire logic wr_w1c = wr && paddr == `FIPG_OFS_IRQ_STAT;
  wire logic clear_req = wr_ctrl && pwdata[`FIPG_CTRL_CLEAR];
  logic [31:0] rd_mux;
  logic rd_err;

  // Read multiplexer and unmapped detection
  always_comb begin
    rd_mux = 32'h0000_0000;
    rd_err = 1'b0;
    if (lim_lo_hit) begin
      rd_mux = {16'h0000, lim_lo_mem[lim_idx]};
    end else if (lim_hi_hit) begin
      rd_mux = {16'h0000, lim_hi_mem[lim_idx]};
    end else begin
      unique case (paddr)
        `FIPG_OFS_CTRL: rd_mux = {30'h0000_0000, wdg_en_ff, run_ff};
        `FIPG_OFS_STATUS: rd_mux = {25'h000_0000, interlock_ok_in_n, cause_ff, state_ff};
        `FIPG_OFS_IRQ_STAT: rd_mux = {29'h0000_0000, irq_stat_ff};
        `FIPG_OFS_IRQ_MASK: rd_mux = {29'h0000_0000, irq_mask_ff};
        `FIPG_OFS_LANE_MODE: rd_mux = {24'h00_0000, mode_ff};
        `FIPG_OFS_DEADTIME: rd_mux = {16'h0000, dt_ff};
        `FIPG_OFS_CTRL_PERIOD: rd_mux = {8'h00, period_ff};
        `FIPG_OFS_HEARTBEAT: rd_mux = 32'h0000_0000;
        default: rd_err = 1'b1;
      endcase
    end
  end

  // APB answer registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      pready_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff <= psel && penable && !pready_ff;
      prdata_ff <= rd_mux;
      pslverr_ff <= psel && penable && !pready_ff && rd_err;
    end
  end

  // Configuration registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      mode_ff <= `FIPG_RST_LANE_MODE;
      dt_ff <= `FIPG_RST_DEADTIME;
      period_ff <= `FIPG_RST_PERIOD;
      irq_mask_ff <= 3'h0;
      wdg_en_ff <= 1'b0;
    end else if (wr) begin
      if (paddr == `FIPG_OFS_LANE_MODE) mode_ff <= pwdata[7:0];
      if (paddr == `FIPG_OFS_DEADTIME) dt_ff <= pwdata[15:0];
      if (paddr == `FIPG_OFS_CTRL_PERIOD) period_ff <= pwdata[23:0];
      if (paddr == `FIPG_OFS_IRQ_MASK) irq_mask_ff <= pwdata[2:0];
      if (paddr == `FIPG_OFS_CTRL) wdg_en_ff <= pwdata[`FIPG_CTRL_WDG_EN];
    end
  end

  // Safety limit tables, reset to full range
  always_ff @(posedge mclk) begin
    if (rst) begin
      for (int i = 0; i < 8; i++) begin
        lim_lo_mem[i] <= `FIPG_RST_LIM_LO;
        lim_hi_mem[i] <= `FIPG_RST_LIM_HI;
      end
    end else if (wr && lim_lo_hit) begin
      lim_lo_mem[lim_idx] <= pwdata[15:0];
    end else if (wr && lim_hi_hit) begin
      lim_hi_mem[lim_idx] <= pwdata[15:0];
    end
  end

  // ==========================================
  // Fault sources
  logic [1:0] ilk_flt;

  // [R4] Interlock low-time filter per input
  always_ff @(posedge mclk) begin
    for (int i = 0; i < 2; i++) begin
      if (rst || interlock_ok_in_n[i]) begin
        ilk_cnt_ff[i] <= 24'h00_0000;
      end else if (ilk_cnt_ff[i] != ILK_LIM) begin
        ilk_cnt_ff[i] <= ilk_cnt_ff[i] + 24'h00_0001;
      end
    end
  end

  // [R5] A high input, as the pulled-up idle pin reads, never faults
  assign ilk_flt[0] = !interlock_ok_in_n[0] && ilk_cnt_ff[0] == ILK_LIM;
  assign ilk_flt[1] = !interlock_ok_in_n[1] && ilk_cnt_ff[1] == ILK_LIM;

  // [R8] Sample compared against its channel limits
  wire logic lim_hit = adc_valid && fipg_outside(adc_data, lim_lo_mem[adc_chan], lim_hi_mem[adc_chan]);

  // [R7] Heartbeat timeout of 2.5 control periods
  wire logic [25:0] wdg_lim = fipg_wdg_limit(period_ff);
  wire logic wdg_on = wdg_en_ff && period_ff != 24'h00_0000 && state_ff == fipg_pkg::FIPG_ST_RUN;
  wire logic wdg_to = wdg_on && wdg_cnt_ff >= wdg_lim;

  // Heartbeat counter, restarted by each heartbeat write
  always_ff @(posedge mclk) begin
    if (rst || !wdg_on || wr_hb) begin
      wdg_cnt_ff <= 26'h000_0000;
    end else if (!wdg_to) begin
      wdg_cnt_ff <= wdg_cnt_ff + 26'h000_0001;
    end
  end

  // [R6] All sources merged into one event vector
  wire logic [2:0] evt = {wdg_to, lim_hit, |ilk_flt};
  wire logic any_evt = |evt;

  // ==========================================
  // Execution state
  // [R15] Causes stay latched until cleared, a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (rst) begin
      cause_ff <= 3'h0;
    end else begin
      cause_ff <= (clear_req ? 3'h0 : cause_ff) | evt;
    end
  end

  // Run request, dropped on fault so software must re-arm
  always_ff @(posedge mclk) begin
    if (rst || any_evt) begin
      run_ff <= 1'b0;
    end else if (wr_ctrl) begin
      run_ff <= pwdata[`FIPG_CTRL_RUN];
    end
  end

  // [R6] State transitions
  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      fipg_pkg::FIPG_ST_IDLE: if (run_ff) nxt_state = fipg_pkg::FIPG_ST_RUN;
      fipg_pkg::FIPG_ST_RUN: if (!run_ff) nxt_state = fipg_pkg::FIPG_ST_IDLE;
      fipg_pkg::FIPG_ST_FAULT: if (clear_req && cause_ff == 3'h0) nxt_state = fipg_pkg::FIPG_ST_IDLE;
      default: nxt_state = fipg_pkg::FIPG_ST_FAULT;
    endcase
    if (any_evt) nxt_state = fipg_pkg::FIPG_ST_FAULT;
  end

  // State register
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_ff <= fipg_pkg::FIPG_ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // [R1] Interlock output follows the next state
  always_ff @(posedge mclk) begin
    if (rst) begin
      ok_out_n_ff <= 1'b1;
    end else begin
      ok_out_n_ff <= nxt_state != fipg_pkg::FIPG_ST_FAULT;
    end
  end

  // ==========================================
  // Lane pairing and gating
  logic [7:0] lane_mux;

  // [R9] Two consecutive lanes per channel
  for (genvar c = 0; c < 4; c++) begin : g_chan
    logic dt_hi;
    logic dt_lo;
    wire fipg_pkg::fipg_mode_e mode = fipg_pkg::fipg_mode_e'(mode_ff[2*c +: 2]);

    // [R10] Dead time pair driven from the even lane modulator
    fipg_deadtime u_dt (
      .mclk(mclk),
      .rst(rst),
      .sig(mod_sig[2*c]),
      .dt(dt_ff),
      .hi(dt_hi),
      .lo(dt_lo)
    );

    // [R14] Even lane high side, odd lane low side
    always_comb begin
      lane_mux[2*c] = 1'b0;
      lane_mux[2*c+1] = 1'b0;
      unique case (mode)
        fipg_pkg::FIPG_MODE_HL: begin
          lane_mux[2*c] = dt_hi;
          lane_mux[2*c+1] = dt_lo;
        end
        // [R11] Switching lane plus authorization lane
        fipg_pkg::FIPG_MODE_AUTH: begin
          lane_mux[2*c] = mod_sig[2*c];
          lane_mux[2*c+1] = 1'b1;
        end
        // [R12] Each lane straight from its modulator
        fipg_pkg::FIPG_MODE_INDEP: begin
          lane_mux[2*c] = mod_sig[2*c];
          lane_mux[2*c+1] = mod_sig[2*c+1];
        end
        default: begin
          lane_mux[2*c] = 1'b0;
          lane_mux[2*c+1] = 1'b0;
        end
      endcase
    end
  end

  // [R3] Lanes pass only while the next state is running
  wire logic lanes_open = nxt_state == fipg_pkg::FIPG_ST_RUN;

  // Gated output lanes
  always_ff @(posedge mclk) begin
    if (rst) begin
      lane_ff <= 8'h00;
    end else begin
      lane_ff <= lanes_open ? lane_mux : 8'h00;
    end
  end

  // ==========================================
  // Interrupts: sticky events, write one to clear, set wins
  always_ff @(posedge mclk) begin
    if (rst) begin
      irq_stat_ff <= 3'h0;
      irq_ff <= 1'b0;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~(wr_w1c ? pwdata[2:0] : 3'h0)) | evt;
      irq_ff <= |(((irq_stat_ff & ~(wr_w1c ? pwdata[2:0] : 3'h0)) | evt) & irq_mask_ff);
    end
  end

  // Outputs
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign interlock_ok_out_n = ok_out_n_ff;
  assign gate_lane = lane_ff;
  assign irq = irq_ff;

  // ==========================================
  // Checks
  chk_out_fault_low: assert property (@(posedge mclk) disable iff (rst) // [R1]
    (state_ff == fipg_pkg::FIPG_ST_FAULT) == !interlock_ok_out_n)
    else $error("interlock output does not match fault state");

  chk_lanes_blocked: assert property (@(posedge mclk) disable iff (rst) // [R3]
    state_ff != fipg_pkg::FIPG_ST_RUN |-> gate_lane == 8'h00)
    else $error("lanes active outside run state");

  chk_ilk_response: assert property (@(posedge mclk) disable iff (rst) // [R4]
    !interlock_ok_in_n[0] && ilk_cnt_ff[0] == ILK_LIM |=> gate_lane == 8'h00 && !interlock_ok_out_n)
    else $error("interlock fault did not block lanes");

  chk_ilk_idle_ok: assert property (@(posedge mclk) disable iff (rst) // [R5]
    interlock_ok_in_n == 2'b11 |=> ilk_cnt_ff[0] == 24'h00_0000 && ilk_cnt_ff[1] == 24'h00_0000)
    else $error("high interlock input left its filter running");

  chk_limit_block: assert property (@(posedge mclk) disable iff (rst) // [R8]
    lim_hit |=> gate_lane == 8'h00 && state_ff == fipg_pkg::FIPG_ST_FAULT && cause_ff[`FIPG_EVT_LIM])
    else $error("limit crossing did not block lanes");

  chk_wdg_limit: assert property (@(posedge mclk) disable iff (rst) // [R7]
    $rose(cause_ff[`FIPG_EVT_WDG]) |-> $past(wdg_cnt_ff) >= $past(wdg_lim) && $past(wdg_lim) != 26'h000_0000)
    else $error("heartbeat fault before timeout");

  chk_fault_latch: assert property (@(posedge mclk) disable iff (rst) // [R15]
    state_ff == fipg_pkg::FIPG_ST_FAULT && !clear_req |=> state_ff == fipg_pkg::FIPG_ST_FAULT)
    else $error("fault left without software clear");

endmodule : fipg_top

//--- fipg_appliance.sv
// Model of the external appliance on the interlock link.
// Assumes fault_req comes from the bench, synchronous to mclk.
`timescale 1ns/10ps
module fipg_appliance (
  input wire logic mclk, // System clock
  input wire logic [1:0] fault_req, // Bench asks for a fault, one bit per line
  output logic [1:0] ilk_n // Interlock lines into the unit
);
  logic [1:0] drive_ff = 2'b11;
  // high in normal run, pulled low on fault
  always @(posedge mclk) begin
    drive_ff <= ~fault_req;
  end
  // second line is driven high from drive_ff like the first unless pulled low
  assign ilk_n = drive_ff;
endmodule : fipg_appliance

//--- tb.sv
// Self-checking bench of the fault gate unit: APB tasks and scenario sequence.
// Assumes fipg_top with a short interlock filter and the appliance model.
`timescale 1ns/10ps
`include "fipg_regs.svh"
module tb;
  localparam int ILK = 20;
  logic mclk, rst, psel, penable, pwrite, pready, pslverr, irq, out_n;
  logic adc_valid, err;
  logic [1:0] fault_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0] adc_chan;
  logic [15:0] adc_data;
  logic [7:0] mod_sig, gate_lane;
  logic [1:0] ilk_n;
  int failures = 0;
  int num_checks = 0;
  int c;

  // =====================================
  // Clock and instances
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  fipg_top #(.ILK_FILT_CYC(ILK)) DUT (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .interlock_ok_in_n(ilk_n), .interlock_ok_out_n(out_n),
    .adc_valid(adc_valid), .adc_chan(adc_chan), .adc_data(adc_data), .mod_sig(mod_sig),
    .gate_lane(gate_lane), .irq(irq));
  fipg_appliance u_app (.mclk(mclk), .fault_req(fault_req), .ilk_n(ilk_n));

  // =====================================
  // Tasks
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  // One APB transfer; holds the request until pready is sampled high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      failures++;
      end_of_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask : cyc

  // Counts cycles until the interlock output falls
  task automatic wait_fault();
    c = 0;
    while (out_n !== 1'b0 && c < 80) begin
      @(posedge mclk);
      c++;
    end
    @(negedge mclk);
  endtask : wait_fault

  task automatic adc(input logic [2:0] ch, input logic [15:0] d);
    @(posedge mclk);
    adc_valid <= 1'b1;
    adc_chan <= ch;
    adc_data <= d;
    @(posedge mclk);
    adc_valid <= 1'b0;
    cyc(1);
  endtask : adc

  // First clear drops the latched causes, the second leaves the fault state
  task automatic recover(input logic [31:0] ctl);
    apb(1'b1, `FIPG_OFS_CTRL, 32'h0000_0004);
    apb(1'b1, `FIPG_OFS_IRQ_STAT, 32'h0000_0007);
    apb(1'b1, `FIPG_OFS_CTRL, 32'h0000_0004);
    apb(1'b1, `FIPG_OFS_CTRL, ctl);
  endtask : recover

  // =====================================
  // Scenario sequence
  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, adc_valid} = 4'h0;
    fault_req = 2'b00;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    adc_chan = 3'h0;
    adc_data = 16'h0000;
    mod_sig = 8'h00;
    repeat (16) @(posedge mclk);
    rst <= 1'b0;
    cyc(1);
    chk("out_n idle", out_n, 1'b1);
    chk("gate reset", gate_lane, 8'h00);
    apb(1'b0, `FIPG_OFS_LIM_LO, 32'h0); chk("lim_lo", rd, 32'h0000_8000);
    apb(1'b0, `FIPG_OFS_LIM_HI, 32'h0); chk("lim_hi", rd, 32'h0000_7FFF);
    apb(1'b0, `FIPG_OFS_LANE_MODE, 32'h0); chk("mode", rd, 32'h0000_0000);
    apb(1'b0, 12'h100, 32'h0); chk("unmapped", {rd[30:0], err}, 32'h1);
    $display("test reset done");
    // Lane pairing modes
    mod_sig <= 8'h5A;
    apb(1'b1, `FIPG_OFS_LANE_MODE, 32'h0000_00AA);
    apb(1'b1, `FIPG_OFS_CTRL, 32'h0000_0001);
    cyc(4); chk("indep", gate_lane, 8'h5A);
    apb(1'b1, `FIPG_OFS_LANE_MODE, 32'h0000_0055);
    cyc(4); chk("auth", gate_lane, 8'hFA);
    mod_sig <= 8'h05;
    apb(1'b1, `FIPG_OFS_DEADTIME, 32'h0000_000A);
    apb(1'b1, `FIPG_OFS_LANE_MODE, 32'h0000_0000);
    cyc(30); chk("hl", gate_lane, 8'hA5);
    @(posedge mclk);
    mod_sig <= 8'h04;
    cyc(4); chk("dt hold", gate_lane[1:0], 2'b00);
    cyc(14); chk("dt done", gate_lane, 8'hA6);
    // Unused pairing code closes its channel
    apb(1'b1, `FIPG_OFS_LANE_MODE, 32'h0000_0003);
    cyc(4); chk("mode3", gate_lane, 8'hA4);
    $display("test lanes done");
    // Analog limit, boundary then crossing
    apb(1'b1, `FIPG_OFS_LIM_HI + 12'h00C, 32'h0000_0064);
    adc(3'd3, 16'h0064); chk("at limit", out_n, 1'b1);
    adc(3'd3, 16'h0065); chk("lim gate", gate_lane, 8'h00);
    chk("lim out", out_n, 1'b0);
    apb(1'b0, `FIPG_OFS_STATUS, 32'h0); chk("lim stat", rd, 32'h0000_006A);
    cyc(2); chk("irq masked", irq, 1'b0);
    apb(1'b1, `FIPG_OFS_IRQ_MASK, 32'h0000_0002);
    cyc(1); chk("irq on", irq, 1'b1);
    apb(1'b1, `FIPG_OFS_IRQ_STAT, 32'h0000_0002);
    cyc(1); chk("irq clr", irq, 1'b0);
    chk("latched", gate_lane, 8'h00);
    $display("test limit done");
    // Interlock: short pulse ignored, long low faults
    recover(32'h0000_0001);
    fault_req <= 2'b01;
    cyc(ILK - 5);
    fault_req <= 2'b00;
    cyc(8); chk("short pulse", out_n, 1'b1);
    fault_req <= 2'b01;
    wait_fault(); chk("ilk delay", c >= ILK && c <= ILK + 4, 1'b1);
    chk("ilk gate", gate_lane, 8'h00);
    fault_req <= 2'b00;
    cyc(8); chk("ilk latch", out_n, 1'b0);
    apb(1'b0, `FIPG_OFS_STATUS, 32'h0); chk("ilk stat", rd, 32'h0000_0066);
    // Second interlock line pulled low
    recover(32'h0000_0001);
    fault_req <= 2'b10;
    wait_fault(); chk("ilk2 delay", c >= ILK && c <= ILK + 4, 1'b1);
    apb(1'b0, `FIPG_OFS_STATUS, 32'h0); chk("ilk2 stat", rd, 32'h0000_0026);
    fault_req <= 2'b00;
    $display("test interlock done");
    // Heartbeat timer: fed, then starved
    recover(32'h0000_0000);
    apb(1'b1, `FIPG_OFS_CTRL_PERIOD, 32'h0000_0008);
    apb(1'b1, `FIPG_OFS_CTRL, 32'h0000_0003);
    repeat (6) apb(1'b1, `FIPG_OFS_HEARTBEAT, 32'h0);
    chk("fed", out_n, 1'b1);
    wait_fault(); chk("wdg delay", c >= 16 && c <= 24, 1'b1);
    apb(1'b0, `FIPG_OFS_STATUS, 32'h0); chk("wdg stat", rd, 32'h0000_0072);
    $display("test heartbeat done");
    end_of_test();
  end

  // Overall run limit
  initial begin
    #400000;
    failures++;
    end_of_test();
  end
endmodule : tb
